// [rtl/dsx_map.vh]
// constants for the decrement and skip execution block
`ifndef DSX_MAP_VH
`define DSX_MAP_VH
// ------------------------------------------------------------
// apb register byte offsets
// ------------------------------------------------------------
`define DSX_OFF_CTRL    8'h00
`define DSX_OFF_BANK    8'h04
`define DSX_OFF_WREG    8'h08
`define DSX_OFF_FLAGS   8'h0C
`define DSX_OFF_INFO    8'h10
`define DSX_OFF_CYCLES  8'h14
// ------------------------------------------------------------
// opcode fields
// ------------------------------------------------------------
`define DSX_OPC_MSB     15
`define DSX_OPC_LSB     10
`define DSX_OPC_DEC     6'h01
`define DSX_OPC_DSZ     6'h0B
`define DSX_BIT_DEST    9
`define DSX_BIT_ACC     8
`define DSX_ADDR_MSB    7
// ------------------------------------------------------------
// access bank split
// ------------------------------------------------------------
`define DSX_ACC_SPLIT   8'h80
`define DSX_ACC_LO_BANK 4'h0
`define DSX_ACC_HI_BANK 4'hF
// ------------------------------------------------------------
// flag bit positions in the flag register
// ------------------------------------------------------------
`define DSX_FLG_C       0
`define DSX_FLG_DC      1
`define DSX_FLG_Z       2
`define DSX_FLG_OV      3
`define DSX_FLG_N       4
// ------------------------------------------------------------
// phase, overflow source and reset values
// ------------------------------------------------------------
`define DSX_Q1          2'h0
`define DSX_Q2          2'h1
`define DSX_Q3          2'h2
`define DSX_Q4          2'h3
`define DSX_OV_SRC      8'h80
`define DSX_RST_CTRL    1'h1
`define DSX_RST_BANK    4'h0
`define DSX_RST_W       8'h00
`define DSX_RST_FLAGS   5'h00
`endif

// [rtl/dsx_core.v]
// execution logic for the two decrement-a-register instructions
`timescale 1ns/1ps
`include "dsx_map.vh"

// Behaviour
// - opcode 000001da with 8-bit address decrements register and updates all five flags
// - destination bit 0 sends result to accumulator, 1 writes it back to register
// - access bit 0 selects access bank, 1 uses the bank pointer register
// - decrement-and-skip routes result by destination bit and leaves flags alone
// - opcode 001011da skips: zero result discards next instruction, runs one no-op cycle
// - skip over a two-word instruction inserts two no-op cycles, three in total
// - one word, one cycle: decode, read, process, write across four phases
module dsx_core (
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  input  wire [15:0] instr_i,
  input  wire        instr_valid_i,
  input  wire        next_two_word_i,
  output wire        instr_ready_o,
  output wire        discard_o,
  output wire [11:0] mem_addr_o,
  output wire        mem_re_o,
  output wire        mem_we_o,
  output wire [7:0]  mem_wdata_o,
  input  wire [7:0]  mem_rdata_i,
  output wire [7:0]  w_o,
  output wire [4:0]  flags_o,
  output wire [1:0]  q_phase_o
);

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_EXEC = 2'h1;
  localparam [1:0] ST_NOP1 = 2'h2;
  localparam [1:0] ST_NOP2 = 2'h3;

  reg  [1:0]  state_reg;
  reg  [1:0]  phase_reg;
  reg  [15:0] op_reg;
  reg         two_word_reg;
  reg  [7:0]  data_reg;
  reg  [7:0]  res_reg;
  reg  [4:0]  newflg_reg;
  reg  [11:0] mem_addr_reg;
  reg         mem_re_reg;
  reg         mem_we_reg;
  reg  [7:0]  mem_wdata_reg;
  reg         ready_reg;
  reg         discard_reg;
  reg         enable_reg;
  reg  [3:0]  bank_reg;
  reg  [7:0]  w_reg;
  reg  [4:0]  flags_reg;
  reg         last_skip_reg;
  reg         unsup_reg;
  reg  [1:0]  cyc_run_reg;
  reg  [1:0]  cycles_reg;
  reg  [31:0] prdata_reg;
  reg         pready_reg;
  reg         pslverr_reg;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function [11:0] dsx_bank_addr;
    input [15:0] op;
    input [3:0]  bank;
    begin
      if (!op[`DSX_BIT_ACC]) begin
        if (op[`DSX_ADDR_MSB:0] < `DSX_ACC_SPLIT)
          dsx_bank_addr = {`DSX_ACC_LO_BANK, op[`DSX_ADDR_MSB:0]};
        else
          dsx_bank_addr = {`DSX_ACC_HI_BANK, op[`DSX_ADDR_MSB:0]};
      end else begin
        dsx_bank_addr = {bank, op[`DSX_ADDR_MSB:0]};
      end
    end
  endfunction

  function is_op;
    input [15:0] op;
    input [5:0]  code;
    begin
      is_op = (op[`DSX_OPC_MSB:`DSX_OPC_LSB] == code);
    end
  endfunction

  wire        op_dec   = is_op(op_reg, `DSX_OPC_DEC);
  wire        op_dsz   = is_op(op_reg, `DSX_OPC_DSZ);
  wire        op_known = op_dec | op_dsz;
  wire        to_reg   = op_reg[`DSX_BIT_DEST];
  // wraps modulo 256 with no extra logic
  wire [7:0]  dec_val  = data_reg - 8'h01;
  wire        skip_now = op_dsz & (res_reg == 8'h00);
  // no borrow out of bit 7 or bit 3 keeps carry or digit carry set
  wire        flg_c    = (data_reg != 8'h00);
  wire        flg_dc   = (data_reg[3:0] != 4'h0);
  wire        flg_ov   = (data_reg == `DSX_OV_SRC);
  wire        flg_z    = (dec_val == 8'h00);
  wire        flg_n    = dec_val[7];

  // ------------------------------------------------------------
  // apb access decode
  // ------------------------------------------------------------
  wire        apb_setup = psel_i & ~penable_i;
  wire        apb_wr    = psel_i & penable_i & pready_reg & pwrite_i;
  wire        core_w_wr = (state_reg == ST_EXEC) && (phase_reg == `DSX_Q4)
                          && op_known && !to_reg;
  wire        core_f_wr = (state_reg == ST_EXEC) && (phase_reg == `DSX_Q4) && op_dec;
  wire        wr_ctrl   = apb_wr && (paddr_i == `DSX_OFF_CTRL);
  wire        wr_bank   = apb_wr && (paddr_i == `DSX_OFF_BANK);
  wire        wr_wreg   = apb_wr && (paddr_i == `DSX_OFF_WREG);
  wire        wr_flags  = apb_wr && (paddr_i == `DSX_OFF_FLAGS);

  reg  [31:0] rd_mux;
  reg         rd_bad;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_bad = 1'b0;
    case (paddr_i)
      `DSX_OFF_CTRL:   rd_mux = {31'h0000_0000, enable_reg};
      `DSX_OFF_BANK:   rd_mux = {28'h000_0000, bank_reg};
      `DSX_OFF_WREG:   rd_mux = {24'h00_0000, w_reg};
      `DSX_OFF_FLAGS:  rd_mux = {27'h000_0000, flags_reg};
      `DSX_OFF_INFO:   rd_mux = {27'h000_0000, phase_reg, unsup_reg, last_skip_reg,
                                 ~ready_reg};
      `DSX_OFF_CYCLES: rd_mux = {30'h0000_0000, cycles_reg};
      default:         rd_bad = 1'b1;
    endcase
  end

  // ------------------------------------------------------------
  // apb slave: no wait state, answer registered in setup
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      enable_reg  <= `DSX_RST_CTRL;
      bank_reg    <= `DSX_RST_BANK;
    end else begin
      pready_reg  <= apb_setup;
      pslverr_reg <= apb_setup & rd_bad;
      prdata_reg  <= apb_setup ? rd_mux : 32'h0000_0000;
      if (wr_ctrl)
        enable_reg <= pwdata_i[0];
      if (wr_bank)
        bank_reg <= pwdata_i[3:0];
    end
  end

  // ------------------------------------------------------------
  // accumulator and flags, core write beats software
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      w_reg     <= `DSX_RST_W;
      flags_reg <= `DSX_RST_FLAGS;
    end else begin
      // a lost software write is retried, a lost result could not be
      if (core_w_wr)
        w_reg <= res_reg;
      else if (wr_wreg)
        w_reg <= pwdata_i[7:0];
      if (core_f_wr)
        flags_reg <= newflg_reg;
      else if (wr_flags)
        flags_reg <= pwdata_i[4:0];
    end
  end

  // ------------------------------------------------------------
  // instruction sequencer, four phases per instruction cycle
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg     <= ST_IDLE;
      phase_reg     <= `DSX_Q1;
      op_reg        <= 16'h0000;
      two_word_reg  <= 1'b0;
      data_reg      <= 8'h00;
      res_reg       <= 8'h00;
      newflg_reg    <= 5'h00;
      mem_addr_reg  <= 12'h000;
      mem_re_reg    <= 1'b0;
      mem_we_reg    <= 1'b0;
      mem_wdata_reg <= 8'h00;
      ready_reg     <= 1'b0;
      discard_reg   <= 1'b0;
      last_skip_reg <= 1'b0;
      unsup_reg     <= 1'b0;
      cyc_run_reg   <= 2'h0;
      cycles_reg    <= 2'h0;
    end else begin
      discard_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          ready_reg <= enable_reg;
          phase_reg <= `DSX_Q1;
          if (instr_valid_i && ready_reg) begin
            op_reg       <= instr_i;
            two_word_reg <= next_two_word_i;
            ready_reg    <= 1'b0;
            cyc_run_reg  <= 2'h1;
            state_reg    <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          phase_reg <= phase_reg + 2'h1;
          case (phase_reg)
            `DSX_Q1: begin
              mem_addr_reg <= dsx_bank_addr(op_reg, bank_reg);
              mem_re_reg   <= op_known;
              unsup_reg    <= ~op_known;
            end
            `DSX_Q2: begin
              mem_re_reg <= 1'b0;
              data_reg   <= mem_rdata_i;
            end
            `DSX_Q3: begin
              res_reg                 <= dec_val;
              newflg_reg[`DSX_FLG_C]  <= flg_c;
              newflg_reg[`DSX_FLG_DC] <= flg_dc;
              newflg_reg[`DSX_FLG_Z]  <= flg_z;
              newflg_reg[`DSX_FLG_OV] <= flg_ov;
              newflg_reg[`DSX_FLG_N]  <= flg_n;
              mem_we_reg              <= op_known & to_reg;
              mem_wdata_reg           <= dec_val;
            end
            default: begin
              mem_we_reg    <= 1'b0;
              last_skip_reg <= skip_now;
              if (skip_now) begin
                // fetched word is dropped, a no-op runs in its slot
                discard_reg <= 1'b1;
                cyc_run_reg <= cyc_run_reg + 2'h1;
                state_reg   <= ST_NOP1;
              end else begin
                cycles_reg <= cyc_run_reg;
                ready_reg  <= enable_reg;
                state_reg  <= ST_IDLE;
              end
            end
          endcase
        end
        ST_NOP1: begin
          phase_reg <= phase_reg + 2'h1;
          if (phase_reg == `DSX_Q4) begin
            if (two_word_reg) begin
              // second word of the skipped instruction needs its own slot
              cyc_run_reg <= cyc_run_reg + 2'h1;
              state_reg   <= ST_NOP2;
            end else begin
              cycles_reg <= cyc_run_reg;
              ready_reg  <= enable_reg;
              state_reg  <= ST_IDLE;
            end
          end
        end
        ST_NOP2: begin
          phase_reg <= phase_reg + 2'h1;
          if (phase_reg == `DSX_Q4) begin
            cycles_reg <= cyc_run_reg;
            ready_reg  <= enable_reg;
            state_reg  <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata_o      = prdata_reg;
  assign pready_o      = pready_reg;
  assign pslverr_o     = pslverr_reg;
  assign instr_ready_o = ready_reg;
  assign discard_o     = discard_reg;
  assign mem_addr_o    = mem_addr_reg;
  assign mem_re_o      = mem_re_reg;
  assign mem_we_o      = mem_we_reg;
  assign mem_wdata_o   = mem_wdata_reg;
  assign w_o           = w_reg;
  assign flags_o       = flags_reg;
  assign q_phase_o     = phase_reg;

endmodule

// [test/dsx_core_sva.sv]
// concurrent checks on the ports of the decrement and skip block
`timescale 1ns/1ps
module dsx_core_sva (
  input wire        clk_i,
  input wire        nrst_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pready_o,
  input wire [15:0] instr_i,
  input wire        instr_valid_i,
  input wire        instr_ready_o,
  input wire        discard_o,
  input wire [11:0] mem_addr_o,
  input wire        mem_re_o,
  input wire        mem_we_o,
  input wire [7:0]  mem_wdata_o,
  input wire [7:0]  mem_rdata_i,
  input wire [4:0]  flags_o,
  input wire [1:0]  q_phase_o
);
  // -------------------------
  // word taken by the core
  // -------------------------
  reg  [15:0] op_reg;
  wire        dsz = op_reg[15:10] == 6'h0B;
  wire        known = dsz || (op_reg[15:10] == 6'h01);
  always @(posedge clk_i or negedge nrst_i)
    if (!nrst_i) op_reg <= 16'h0000;
    else if (instr_valid_i && instr_ready_o) op_reg <= instr_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_apb_ready: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no answer after setup");
  a_strobe_phase: assert property (mem_re_o |-> q_phase_o == 2'h1 ##2 q_phase_o == 2'h3)
    else $error("read strobe off its phase");
  a_we_after_re: assert property (mem_we_o |-> $past(mem_re_o, 2) && q_phase_o == 2'h3)
    else $error("write strobe off its phase");
  a_take_start: assert property (instr_valid_i && instr_ready_o |=> !instr_ready_o ##1 mem_re_o == known)
    else $error("read not in second clock");
  a_wdata_dec: assert property (mem_we_o |-> mem_wdata_o == $past(mem_rdata_i, 2) - 8'h01)
    else $error("written value not one less");
  a_addr_bank: assert property (mem_re_o |-> mem_addr_o[7:0] == op_reg[7:0] && (op_reg[8] ||
    mem_addr_o[11:8] == (op_reg[7] ? 4'hF : 4'h0)))
    else $error("wrong data address");
  a_skip_flags: assert property (dsz && q_phase_o == 2'h3 |=> $stable(flags_o))
    else $error("skip op changed flags");
  a_discard_zero: assert property (discard_o |-> dsz && $past(mem_rdata_i, 3) == 8'h01)
    else $error("discard without zero result");
  a_skip_taken: assert property (dsz && mem_re_o && mem_rdata_i == 8'h01 |-> ##3 discard_o)
    else $error("zero result did not skip");
  a_idle_gap: assert property (discard_o |=> !instr_ready_o [*3])
    else $error("ready during no-op cycle");
  c_skip: cover property (discard_o);
  c_write: cover property (mem_we_o);
  c_take: cover property (instr_valid_i && instr_ready_o);
endmodule
bind dsx_core dsx_core_sva u_sva (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
  .instr_ready_o(instr_ready_o), .discard_o(discard_o), .mem_addr_o(mem_addr_o),
  .mem_re_o(mem_re_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
  .mem_rdata_i(mem_rdata_i), .flags_o(flags_o), .q_phase_o(q_phase_o));

// [test/dsx_mem_model.sv]
// data memory model on the far side of the block
`timescale 1ns/1ps
module dsx_mem_model (
  input  wire        clk_i,
  input  wire [11:0] mem_addr_i,
  input  wire        mem_re_i,
  input  wire        mem_we_i,
  input  wire [7:0]  mem_wdata_i,
  output wire [7:0]  mem_rdata_o
);
  reg [7:0] ram [0:4095];
  reg [7:0] last_reg = 8'h5A;
  // inverted stale value outside a read, so a late sample never matches
  assign mem_rdata_o = mem_re_i ? ram[mem_addr_i] : ~last_reg;
  always @(posedge clk_i) begin
    if (mem_re_i) last_reg <= ram[mem_addr_i];
    if (mem_we_i) ram[mem_addr_i] <= mem_wdata_i;
  end
endmodule

// [test/test_decrement_skip_exec.sv]
// self-checking bench for the decrement and skip block
`timescale 1ns/1ps
module test_decrement_skip_exec;
  reg         clk_i, nrst_i, psel_i, penable_i, pwrite_i, instr_valid_i, next_two_word_i;
  reg  [7:0]  paddr_i;
  reg  [31:0] pwdata_i;
  reg  [15:0] instr_i;
  wire [31:0] prdata_o;
  wire        pready_o, pslverr_o, instr_ready_o, discard_o, mem_re_o, mem_we_o;
  wire [11:0] mem_addr_o;
  wire [7:0]  mem_wdata_o, mem_rdata_i, w_o;
  wire [4:0]  flags_o;
  wire [1:0]  q_phase_o;
  integer     err_count = 0;
  integer     checked = 0;
  dsx_core DUT (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .next_two_word_i(next_two_word_i),
    .instr_ready_o(instr_ready_o), .discard_o(discard_o), .mem_addr_o(mem_addr_o),
    .mem_re_o(mem_re_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i), .w_o(w_o), .flags_o(flags_o), .q_phase_o(q_phase_o));
  dsx_mem_model mem (.clk_i(clk_i), .mem_addr_i(mem_addr_o), .mem_re_i(mem_re_o),
    .mem_we_i(mem_we_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));
  // -------------------------
  // shared tasks
  // -------------------------
  task complete_run;
    begin
      $display("mismatches %0d of %0d checks", err_count, checked);
      if (err_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wait_out;
    begin
      err_count = err_count + 1;
      $display("[ERR] %0t wait ran out", $time);
      complete_run;
    end
  endtask
  // request held until pready is seen high at a rising edge, data taken there
  task apb(input wr, input [7:0] a, input [31:0] d, input [31:0] exp, input ex_err);
    integer n;
    begin
      @(posedge clk_i);
      psel_i    <= 1'b1;
      pwrite_i  <= wr;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      @(posedge clk_i);
      while (pready_o !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge clk_i);
      end
      if (n == 20) wait_out;
      if (!wr) chk(prdata_o, exp);
      chk({31'h0, pslverr_o}, {31'h0, ex_err});
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask
  // valid held until ready is seen at an edge; skip cycles must hold the fetch off
  task run(input [15:0] op, input two, input [11:0] a, input [7:0] init, input [7:0] em,
           input [7:0] ew, input [4:0] ef, input [1:0] cyc);
    integer n;
    begin
      mem.ram[a] = init;
      @(posedge clk_i);
      instr_i         <= op;
      next_two_word_i <= two;
      instr_valid_i   <= 1'b1;
      n = 0;
      @(posedge clk_i);
      while (instr_ready_o !== 1'b1 && n < 50) begin
        n = n + 1;
        @(posedge clk_i);
      end
      if (n == 50) wait_out;
      instr_valid_i <= 1'b0;
      n = 1;
      @(posedge clk_i);
      while (instr_ready_o !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge clk_i);
      end
      if (n == 20) wait_out;
      chk(n, 4 * cyc + 1);
      chk(mem.ram[a], em);
      chk(w_o, ew);
      chk(flags_o, ef);
      apb(1'b0, 8'h14, 32'h0, cyc, 1'b0);
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // -------------------------
  // main sequence
  // -------------------------
  initial begin
    {nrst_i, psel_i, penable_i, pwrite_i, instr_valid_i, next_two_word_i} = 6'h00;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    instr_i = 16'h0000;
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, 32'h1, 1'b0);
    apb(1'b0, 8'h0C, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h18, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h04, 32'h3, 32'h0, 1'b0);
    apb(1'b0, 8'h04, 32'h0, 32'h3, 1'b0);
    run(16'h0755, 1'b0, 12'h355, 8'h01, 8'h00, 8'h00, 5'h07, 2'h1);
    run(16'h0490, 1'b0, 12'hF90, 8'h00, 8'h00, 8'hFF, 5'h10, 2'h1);
    run(16'h2E10, 1'b0, 12'h010, 8'h01, 8'h00, 8'hFF, 5'h10, 2'h2);
    run(16'h2D20, 1'b1, 12'h320, 8'h01, 8'h01, 8'h00, 5'h10, 2'h3);
    run(16'h2F30, 1'b1, 12'h330, 8'h05, 8'h04, 8'h00, 5'h10, 2'h1);
    run(16'h0680, 1'b0, 12'hF80, 8'h80, 8'h7F, 8'h00, 5'h09, 2'h1);
    // foreign opcode: no access, no write, flagged in the info register
    run(16'h1044, 1'b0, 12'h044, 8'h33, 8'h33, 8'h00, 5'h09, 2'h1);
    apb(1'b0, 8'h10, 32'h0, 32'h4, 1'b0);
    apb(1'b1, 8'h08, 32'hA5, 32'h0, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 32'hA5, 1'b0);
    apb(1'b1, 8'h0C, 32'h1B, 32'h0, 1'b0);
    run(16'h2E7F, 1'b0, 12'h07F, 8'h02, 8'h01, 8'hA5, 5'h1B, 2'h1);
    apb(1'b1, 8'h00, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'h1, 1'b0);
    chk({31'h0, instr_ready_o}, 32'h0);
    apb(1'b1, 8'h00, 32'h1, 32'h0, 1'b0);
    // reset while the core idles between instructions, then a bank read and a first instruction
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({24'h0, w_o}, 32'h0);
    chk({27'h0, flags_o}, 32'h0);
    chk({31'h0, instr_ready_o}, 32'h0);
    nrst_i <= 1'b1;
    apb(1'b0, 8'h04, 32'h0, 32'h0, 1'b0);
    run(16'h0755, 1'b0, 12'h055, 8'h01, 8'h00, 8'h00, 5'h07, 2'h1);
    complete_run;
  end
  initial begin
    #1000000;
    wait_out;
  end
endmodule
